/* rtl/dcs_i2c_slave.sv */
/*
 * Two-wire serial slave of a volatile converter: framing, general call,
 * start/stop recovery and committed register bank.
 * Assumes scl is the bus clock (stands still outside frames), sda is
 * open drain with an external pull-up, and mclk runs free at 250 MHz.
 */
module dcs_i2c_slave (
   // System clock and reset
   input  wire logic             mclk,
   input  wire logic             sys_rst,
   // Serial bus
   input  wire logic             scl,
   input  wire logic             sda_in,
   output logic                  sda_out,
   output logic                  sda_oe,
   // Converter side
   output dcs_pkg::dcs_bank_t    dac_code,
   output logic                  gc_reset_pulse,
   output logic                  wake_pulse
);
   import dcs_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // System domain: pin filter and start/stop detection
   dcs_pins_s  pin_raw;
   dcs_pins_s  pin_clean;
   dcs_pins_s  pin_prev;
   logic       start_det;
   logic       stop_det;

   assign pin_raw.scl = scl;
   assign pin_raw.sda = sda_in;

   dcs_pin_sync u_sync (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .pin_raw   (pin_raw),
      .pin_clean (pin_clean)
   );

   // Previous filtered levels for edge detection
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_prev <= '1;
      end else begin
         pin_prev <= pin_clean;
      end
   end

   // Sda edges while scl stays high
   assign start_det = pin_prev.scl & pin_clean.scl &
                      pin_prev.sda & ~pin_clean.sda;
   assign stop_det  = pin_prev.scl & pin_clean.scl &
                      ~pin_prev.sda & pin_clean.sda;

   ////////////////////////////////////////////////////////////////////////
   // Link reset control; link logic is reset asynchronously from here since
   // scl gives no edges to carry a synchronous abort in time
   logic       link_rst;
   logic       parked;
   logic [3:0] rel_cnt;
   logic       next_parked;
   logic [3:0] next_rel_cnt;

   always_comb begin
      next_parked  = parked;
      next_rel_cnt = rel_cnt;
      if (start_det) begin
         next_parked  = 1'b0;
         next_rel_cnt = RELEASE_CYC;
      end else if (stop_det) begin
         next_parked  = 1'b1;
      end else if (rel_cnt != 4'h0) begin
         next_rel_cnt = rel_cnt - 4'h1;
      end
   end

   // Held while parked or stretching past a start; bank is untouched
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         parked   <= 1'b1;
         rel_cnt  <= 4'h0;
         link_rst <= 1'b1;
      end else begin
         parked   <= next_parked;
         rel_cnt  <= next_rel_cnt;
         link_rst <= next_parked | (next_rel_cnt != 4'h0);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Link domain: byte engine on the rising scl edge
   dcs_state_e       state;
   dcs_state_e       next_state;
   logic [3:0]       cnt;
   logic [3:0]       next_cnt;
   logic [7:0]       sh;
   logic [7:0]       next_sh;
   logic [7:0]       tx;
   logic [7:0]       next_tx;
   logic [7:0]       hi;
   logic [7:0]       next_hi;
   logic [7:0]       byte_in;
   logic             ack;
   logic             next_ack;
   logic             rw;
   logic             next_rw;
   logic             half;
   logic             next_half;
   logic [NREG-1:0]  mask;
   logic [NREG-1:0]  next_mask;
   logic [1:0]       gc;
   logic [1:0]       next_gc;
   dcs_bank_t        stage;
   dcs_bank_t        next_stage;
   logic [1:0]       ptr;
   logic [1:0]       next_ptr;
   logic [4:0]       cmd_addr;
   logic [1:0]       cmd_op;

   assign byte_in  = {sh[6:0], sda_in};
   assign cmd_addr = byte_in[CMD_A_MSB:CMD_A_LSB];
   assign cmd_op   = byte_in[CMD_OP_MSB:CMD_OP_LSB];

   // Bank is read across domains only inside a frame; it changes only while
   // the link is held in reset, so the words are quiet when sampled here
   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      next_sh    = sh;
      next_tx    = tx;
      next_hi    = hi;
      next_ack   = ack;
      next_rw    = rw;
      next_half  = half;
      next_mask  = mask;
      next_gc    = gc;
      next_stage = stage;
      next_ptr   = ptr;
      if (cnt != ACK_SLOT) begin
         next_cnt = cnt + 4'h1;
         next_sh  = byte_in;
         next_tx  = {tx[6:0], 1'b0};
         if (cnt == LAST_BIT) begin
            case (state)
               ST_ADDR: begin
                  // Foreign codes, such as a fast-mode entry code, are
                  // left unanswered and the frame is skipped
                  if (byte_in[7:1] == DEV_ADDR) begin
                     next_ack = 1'b1;
                     next_rw  = byte_in[0];
                  end else if (byte_in == GC_ADDR) begin
                     next_ack = 1'b1;
                     next_gc  = 2'b00;
                     next_rw  = 1'b0;
                  end
               end
               ST_CMD: begin
                  // Bit 0 picks the voltage variant; both are served
                  if ((cmd_op == OP_WRITE || cmd_op == OP_READ) &&
                      cmd_addr < 5'(NREG)) begin
                     next_ack = 1'b1;
                     next_ptr = cmd_addr[1:0];
                     next_rw  = (cmd_op == OP_READ);
                  end
               end
               ST_HI: begin
                  next_ack = 1'b1;
                  next_hi  = byte_in;
               end
               ST_LO: begin
                  // Staged only; the bank takes it at the stop
                  next_ack        = 1'b1;
                  next_stage[ptr] = {hi, byte_in};
                  next_mask[ptr]  = 1'b1;
               end
               ST_GC: begin
                  if (byte_in == GC_RESET) begin
                     next_ack = 1'b1;
                     next_gc[GC_RST_BIT] = 1'b1;
                  end else if (byte_in == GC_WAKE) begin
                     next_ack = 1'b1;
                     next_gc[GC_WK_BIT]  = 1'b1;
                  end
               end
               default: begin
                  next_ack = 1'b0;
               end
            endcase
         end
      end else begin
         next_cnt = 4'h0;
         next_ack = 1'b0;
         case (state)
            ST_ADDR: begin
               if (!ack) begin
                  next_state = ST_SKIP;
               end else if (rw) begin
                  next_state = ST_READ;
                  next_tx    = dac_code[ptr][15:8];
                  next_half  = 1'b0;
               end else if (byte_in == GC_ADDR) begin
                  next_state = ST_GC;
               end else begin
                  next_state = ST_CMD;
               end
            end
            ST_CMD: begin
               // A read command waits for the repeated start
               next_state = (ack && !rw) ? ST_HI : ST_SKIP;
            end
            ST_HI: begin
               next_state = ST_LO;
            end
            ST_LO: begin
               next_state = ST_CMD;
            end
            ST_READ: begin
               if (sda_in) begin
                  next_state = ST_SKIP;
               end else begin
                  next_half = ~half;
                  next_tx   = half ? dac_code[ptr][15:8]
                                   : dac_code[ptr][7:0];
               end
            end
            default: begin
               next_state = ST_SKIP;
            end
         endcase
      end
   end

   // Frame state, cleared by any start or stop
   always_ff @(posedge scl or posedge link_rst) begin
      if (link_rst) begin
         state <= ST_ADDR;
         cnt   <= 4'h0;
         sh    <= 8'h00;
         tx    <= 8'h00;
         hi    <= 8'h00;
         ack   <= 1'b0;
         rw    <= 1'b0;
         half  <= 1'b0;
         mask  <= '0;
         gc    <= 2'b00;
         stage <= '0;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
         sh    <= next_sh;
         tx    <= next_tx;
         hi    <= next_hi;
         ack   <= next_ack;
         rw    <= next_rw;
         half  <= next_half;
         mask  <= next_mask;
         gc    <= next_gc;
         stage <= next_stage;
      end
   end

   // Pointer survives frames so a last-address read can reuse it
   always_ff @(posedge scl or posedge sys_rst) begin
      if (sys_rst) begin
         ptr <= 2'h0;
      end else begin
         ptr <= next_ptr;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Link domain: sda drive changes on the falling scl edge
   logic next_oe;

   always_comb begin
      next_oe = 1'b0;
      if (cnt == ACK_SLOT) begin
         next_oe = ack;
      end else if (state == ST_READ) begin
         next_oe = ~tx[7];
      end
   end

   always_ff @(negedge scl or posedge link_rst) begin
      if (link_rst) begin
         sda_oe  <= 1'b0;
         sda_out <= 1'b0;
      end else begin
         sda_oe  <= next_oe;
         sda_out <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Crossing of stage flags into mclk; staged words are quiet by then
   logic [NREG-1:0] mask_m1;
   logic [NREG-1:0] mask_m2;
   logic [1:0]      gc_m1;
   logic [1:0]      gc_m2;
   logic            commit_now;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         mask_m1 <= '0;
         mask_m2 <= '0;
         gc_m1   <= 2'b00;
         gc_m2   <= 2'b00;
      end else begin
         mask_m1 <= mask;
         mask_m2 <= mask_m1;
         gc_m1   <= gc;
         gc_m2   <= gc_m1;
      end
   end

   // Only a stop closing a live frame commits anything
   assign commit_now = stop_det & ~parked;

   ////////////////////////////////////////////////////////////////////////
   // Register bank, one entry per converter channel
   for (genvar i = 0; i < NREG; i++) begin : g_reg
      logic [DW-1:0] next_code;

      always_comb begin
         next_code = dac_code[i];
         if (commit_now && gc_m2[GC_RST_BIT]) begin
            next_code = REG_RESET;
         end else if (commit_now && mask_m2[i]) begin
            next_code = stage[i];
         end
      end

      always_ff @(posedge mclk or posedge sys_rst) begin
         if (sys_rst) begin
            dac_code[i] <= REG_RESET;
         end else begin
            dac_code[i] <= next_code;
         end
      end
   end

   // General-call actions fire once, at the closing stop
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         gc_reset_pulse <= 1'b0;
         wake_pulse     <= 1'b0;
      end else begin
         gc_reset_pulse <= commit_now & gc_m2[GC_RST_BIT];
         wake_pulse     <= commit_now & gc_m2[GC_WK_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks, system domain
   sequence start_hold_s;
      start_det ##1 link_rst [*4];
   endsequence

   property start_abort_p;
      @(posedge mclk) disable iff (sys_rst)
      start_det |-> start_hold_s;
   endproperty
   start_abort_a: assert property (start_abort_p)
      else $error("start did not hold the link in reset");

   property stop_idle_p;
      @(posedge mclk) disable iff (sys_rst)
      (stop_det && !start_det) |=> (link_rst && parked) [*8];
   endproperty
   stop_idle_a: assert property (stop_idle_p)
      else $error("link left idle after stop without a start");

   property bank_quiet_p;
      @(posedge mclk) disable iff (sys_rst)
      !commit_now |=> $stable(dac_code);
   endproperty
   bank_quiet_a: assert property (bank_quiet_p)
      else $error("bank changed without a committing stop");

   property commit_stop_p;
      @(posedge mclk) disable iff (sys_rst)
      (commit_now && mask_m2[0] && !gc_m2[GC_RST_BIT]) |=>
         dac_code[0] == $past(stage[0]);
   endproperty
   commit_word_a: assert property (commit_stop_p)
      else $error("staged word not committed at stop");

   property gc_pulse_p;
      @(posedge mclk) disable iff (sys_rst)
      gc_reset_pulse |-> $past(stop_det) && dac_code == '0;
   endproperty
   gc_reset_a: assert property (gc_pulse_p)
      else $error("general-call reset pulse without cleared bank");

   ////////////////////////////////////////////////////////////////////////
   // Checks, link domain
   property nack_read_p;
      @(posedge scl) disable iff (link_rst)
      (state == ST_READ && cnt == ACK_SLOT && sda_in) |=>
         state == ST_SKIP;
   endproperty
   nack_read_a: assert property (nack_read_p)
      else $error("read not abandoned after not-acknowledge");

   property addr_ack_p;
      @(posedge scl) disable iff (link_rst)
      (state == ST_ADDR && cnt == LAST_BIT &&
       byte_in[7:1] == DEV_ADDR) |=> ack ##1 state != ST_SKIP;
   endproperty
   addr_ack_a: assert property (addr_ack_p)
      else $error("own address not acknowledged");

   property hv_cmd_p;
      @(posedge scl) disable iff (link_rst)
      (state == ST_CMD && cnt == LAST_BIT && cmd_op == OP_WRITE &&
       cmd_addr < 5'(NREG)) |=> ack;
   endproperty
   voltage_variant_a: assert property (hv_cmd_p)
      else $error("write command refused for one voltage form");

   property word_cycle_p;
      @(posedge scl) disable iff (link_rst)
      (state == ST_LO && cnt == ACK_SLOT) |=> state == ST_CMD && cnt == 0;
   endproperty
   word_cycle_a: assert property (word_cycle_p)
      else $error("continuous write did not return to command byte");

endmodule : dcs_i2c_slave

/* rtl/dcs_pkg.sv */
/*
 * Shared constants and types of the two-wire converter slave.
 * Assumes a single-clock mclk system domain and a bus-driven scl domain.
 */
package dcs_pkg;

   // Register bank shape
   localparam int               NREG       = 4;
   localparam int               DW         = 16;
   localparam logic [DW-1:0]    REG_RESET  = 16'h0000;

   // Bus addresses and general-call command bytes
   localparam logic [6:0]       DEV_ADDR   = 7'h30; // Arbitrary value
   localparam logic [7:0]       GC_ADDR    = 8'h00;
   localparam logic [7:0]       GC_RESET   = 8'h06;
   localparam logic [7:0]       GC_WAKE    = 8'h0a;

   // Command byte fields: address, operation, voltage variant in bit 0
   localparam int               CMD_A_MSB  = 7;
   localparam int               CMD_A_LSB  = 3;
   localparam int               CMD_OP_MSB = 2;
   localparam int               CMD_OP_LSB = 1;
   localparam logic [1:0]       OP_WRITE   = 2'h0;
   localparam logic [1:0]       OP_READ    = 2'h3;

   // Bit positions within a nine-clock byte slot
   localparam logic [3:0]       LAST_BIT   = 4'h7;
   localparam logic [3:0]       ACK_SLOT   = 4'h8;

   // General-call request flags
   localparam int               GC_RST_BIT = 0;
   localparam int               GC_WK_BIT  = 1;

   // Link release after a start, in ns and in mclk cycles
   localparam int               CLK_PERIOD_NS = 4;
   localparam int               RELEASE_NS    = 32;
   localparam logic [3:0]       RELEASE_CYC   =
      4'(RELEASE_NS / CLK_PERIOD_NS);

   typedef struct packed {
      logic scl;
      logic sda;
   } dcs_pins_s;

   typedef logic [NREG-1:0][DW-1:0] dcs_bank_t;

   typedef enum {ST_ADDR, ST_CMD, ST_HI, ST_LO, ST_GC, ST_READ,
                 ST_SKIP} dcs_state_e;

endpackage : dcs_pkg

/* rtl/dcs_pin_sync.sv */
/*
 * Three-stage synchroniser with agreement filter for scl and sda.
 * Assumes raw pins are asynchronous to mclk; idle bus reads high.
 */
module dcs_pin_sync (
   // System clock and reset
   input  wire logic               mclk,
   input  wire logic               sys_rst,
   // Raw and filtered bus lines
   input  wire dcs_pkg::dcs_pins_s pin_raw,
   output dcs_pkg::dcs_pins_s      pin_clean
);
   import dcs_pkg::*;

   logic [1:0] raw_v;
   logic [1:0] clean_v;

   assign raw_v     = pin_raw;
   assign pin_clean = clean_v;

   ////////////////////////////////////////////////////////////////////////
   // Per line: stage 1 feeds only stage 2; a change counts once 2 and 3 agree
   for (genvar i = 0; i < 2; i++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      logic q;
      logic next_q;

      // Hold last agreed level while stages disagree
      always_comb begin
         next_q = q;
         if (s2 == s3) begin
            next_q = s3;
         end
      end

      always_ff @(posedge mclk or posedge sys_rst) begin
         if (sys_rst) begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
            q  <= 1'b1;
         end else begin
            s1 <= raw_v[i];
            s2 <= s1;
            s3 <= s2;
            q  <= next_q;
         end
      end

      assign clean_v[i] = q;
   end

endmodule : dcs_pin_sync

/* testbench/dcs_bus_master.sv */
/*
 * Behavioural two-wire bus master: start, stop, bytes and recovery.
 * Assumes the bench resolves sda with a pull-up and feeds it back here.
 */
module dcs_bus_master (
   // Bus lines
   output logic      scl,
   output logic      sda_low,
   input  wire logic sda
);
   timeunit 1ns;
   timeprecision 10ps;

   localparam real Q = 31.25; // Quarter of the 125 ns bit period

   logic busy;

   // Idle bus: clock stands high, data released to the pull-up
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
      busy = 1'b0;
   end

   // One bit: data changes mid-low, sampled at the rising edge
   task automatic bit_io(input logic v, output logic s);
      scl = 1'b0;
      #Q sda_low = ~v;
      #Q scl = 1'b1;
      s = sda;
      #(2*Q);
   endtask : bit_io

   // Start or repeated start; the long hold lets the link release settle
   task automatic start;
      if (busy) begin
         scl = 1'b0;
         #Q sda_low = 1'b0;
         #Q scl = 1'b1;
         #(2*Q);
      end
      sda_low = 1'b1;
      #(2*Q);
      busy = 1'b1;
   endtask : start

   // Stop: data rises while the clock is high, then the bus idles
   task automatic stop;
      scl = 1'b0;
      #Q sda_low = 1'b1;
      #Q scl = 1'b1;
      #(2*Q) sda_low = 1'b0;
      #(2*Q) busy = 1'b0;
   endtask : stop

   // Byte out, acknowledge returned (0 means taken)
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(b[i], s);
      bit_io(1'b1, ack);
   endtask : wbyte

   // Byte in, then acknowledge (0) or not-acknowledge (1)
   task automatic rbyte(input logic nack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(nack, s);
   endtask : rbyte

   // Start, nine ones, start, stop: the second start blocks a stray write
   task automatic recover;
      logic s;
      start();
      repeat (9) bit_io(1'b1, s);
      start();
      stop();
   endtask : recover

endmodule : dcs_bus_master

/* testbench/dcs_i2c_slave_framing_reset_test.sv */
/*
 * Self-checking bench of the two-wire converter slave.
 * Assumes the bus master model drives scl and pulls sda against a pull-up.
 */
module dcs_i2c_slave_framing_reset_test;
   timeunit 1ns;
   timeprecision 100ps;
   import dcs_pkg::*;

   logic       mclk = 1'b0;
   logic       sys_rst = 1'b0;
   logic       scl, m_low, sda_oe, sda_out, gc_p, wk_p, ack;
   logic [7:0] d;
   dcs_bank_t  dac_code;
   int         error_cnt = 0;
   int         n_checks = 0;
   int         gc_n = 0;
   int         wk_n = 0;
   // Open-drain wire: low if anyone pulls, else the pull-up wins
   wire        sda = ~(m_low | (sda_oe & ~sda_out));

   dcs_i2c_slave u_dut (.mclk(mclk), .sys_rst(sys_rst), .scl(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .dac_code(dac_code), .gc_reset_pulse(gc_p), .wake_pulse(wk_p));
   dcs_bus_master u_m (.scl(scl), .sda_low(m_low), .sda(sda));

   always #2 mclk = ~mclk;

   // Count one-cycle pulses so none is missed; sampled mid-cycle, settled
   always @(negedge mclk) begin
      if (gc_p === 1'b1) gc_n++;
      if (wk_p === 1'b1) wk_n++;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [15:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic tx(input logic [7:0] b);
      u_m.wbyte(b, ack);
      chk("ack", 16'(ack), 16'h0000);
   endtask : tx

   task automatic rx(input logic nack, input logic [7:0] e);
      u_m.rbyte(nack, d);
      chk("read", 16'(d), 16'(e));
   endtask : rx

   // Commit lands a few mclk after the stop is filtered
   task automatic settle;
      repeat (8) @(posedge mclk);
   endtask : settle

   ////////////////////////////////////////////////////////////////////////
   // Two words in one frame, second in the high-voltage form
   task automatic t_write;
      chk("rst", dac_code[1], 16'h0000);
      u_m.start();
      tx(8'h60); tx(8'h08); tx(8'h12); tx(8'h34);
      tx(8'h11); tx(8'hab); tx(8'hcd);
      settle();
      chk("early", dac_code[1], 16'h0000);
      u_m.stop();
      settle();
      chk("reg1", dac_code[1], 16'h1234);
      chk("reg2", dac_code[2], 16'habcd);
   endtask : t_write

   // Random continuous read, then a read from the last address
   task automatic t_read;
      u_m.start();
      tx(8'h60); tx(8'h17);
      u_m.start();
      tx(8'h61);
      rx(1'b0, 8'hab); rx(1'b0, 8'hcd); rx(1'b0, 8'hab); rx(1'b1, 8'hcd);
      // Line is released after the not-acknowledge: further clocks read ones
      u_m.bit_io(1'b1, ack);
      u_m.bit_io(1'b1, ack);
      chk("nack free", 16'(ack), 16'h0001);
      u_m.stop();
      u_m.start();
      tx(8'h61);
      rx(1'b0, 8'hab); rx(1'b1, 8'hcd);
      u_m.stop();
      settle();
      chk("oe idle", 16'(sda_oe), 16'h0000);
   endtask : t_read

   // A start after a whole word drops it; a new frame then works
   task automatic t_abort;
      u_m.start();
      tx(8'h60); tx(8'h18); tx(8'h55); tx(8'h66);
      u_m.start();
      u_m.stop();
      settle();
      chk("reg3 kept", dac_code[3], 16'h0000);
      u_m.start();
      tx(8'h60); tx(8'h18); tx(8'h55);
      u_m.start();
      tx(8'h60); tx(8'h18); tx(8'h9a); tx(8'hbc);
      u_m.stop();
      settle();
      chk("reg3", dac_code[3], 16'h9abc);
   endtask : t_abort

   // Device stuck driving a zero read bit, freed by the recovery sequence
   task automatic t_recover;
      u_m.start();
      tx(8'h61);
      u_m.bit_io(1'b1, ack);
      u_m.recover();
      settle();
      chk("oe free", 16'(sda_oe), 16'h0000);
      chk("reg3 keep", dac_code[3], 16'h9abc);
      chk("reg1 keep", dac_code[1], 16'h1234);
      u_m.start();
      tx(8'h60); tx(8'h00); tx(8'h0f); tx(8'h0f);
      u_m.stop();
      settle();
      chk("reg0", dac_code[0], 16'h0f0f);
   endtask : t_recover

   // Refused codes go unanswered and skip the frame; after the fast-mode
   // entry code a normal frame still writes
   task automatic t_refuse;
      u_m.start();
      tx(8'h60);
      u_m.wbyte(8'h20, ack);
      chk("bad reg", 16'(ack), 16'h0001);
      u_m.start();
      tx(8'h60);
      u_m.wbyte(8'h02, ack);
      chk("bad op", 16'(ack), 16'h0001);
      u_m.start();
      tx(GC_ADDR);
      u_m.wbyte(8'h55, ack);
      chk("bad gc", 16'(ack), 16'h0001);
      u_m.start();
      u_m.wbyte(8'h08, ack);
      chk("hs code", 16'(ack), 16'h0001);
      u_m.start();
      tx(8'h60); tx(8'h00); tx(8'h12); tx(8'h21);
      u_m.stop();
      settle();
      chk("reg0 hs", dac_code[0], 16'h1221);
      chk("gc none", 16'(gc_n), 16'h0000);
      chk("wk none", 16'(wk_n), 16'h0000);
   endtask : t_refuse

   // General call: wake only pulses, reset pulses and clears the bank
   task automatic t_gc;
      u_m.start();
      tx(GC_ADDR); tx(GC_WAKE);
      u_m.stop();
      settle();
      chk("wake", 16'(wk_n), 16'h0001);
      chk("no rst", 16'(gc_n), 16'h0000);
      chk("wake keep", dac_code[1], 16'h1234);
      u_m.start();
      tx(GC_ADDR); tx(GC_RESET);
      u_m.stop();
      settle();
      chk("gc rst", 16'(gc_n), 16'h0001);
      for (int i = 0; i < NREG; i++) chk("clr", dac_code[i], 16'h0000);
   endtask : t_gc

   ////////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict

   // Main sequence after a four-cycle reset and synchroniser settling
   initial begin
      // Raise reset with an edge so the scl-side flops see it as well
      sys_rst <= 1'b1;
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b0;
      repeat (8) @(posedge mclk);
      t_write();
      t_read();
      t_abort();
      t_recover();
      t_refuse();
      t_gc();
      print_verdict();
   end

   // Hang guard: far beyond the longest frame sequence
   initial begin
      #200000;
      error_cnt++;
      print_verdict();
   end

endmodule : dcs_i2c_slave_framing_reset_test
